// ### core/wd_pkg.sv
// package: watchdog register map, field layout, reset values and timing constants
package wd_pkg;
  // ***************************************************
  // register map
  // ***************************************************
  localparam logic [7:0] WD_CONTROL_COUNT_ADDR = 8'h2d;
  localparam logic [7:0] IRQ_A_ENABLE_ADDR     = 8'h29;
  localparam logic [7:0] IRQ_B_ENABLE_ADDR     = 8'h2a;
  localparam logic [7:0] FLAGS_ADDR            = 8'h2b;
  localparam logic [7:0] IRQ_CTRL_ADDR         = 8'h2e;
  // ***************************************************
  // field positions
  // ***************************************************
  localparam int WD_REPEAT_BIT  = 7;
  localparam int WD_LOAD_MSB    = 6;
  localparam int WD_LOAD_LSB    = 2;
  localparam int WD_STEP_MSB    = 1;
  localparam int WD_STEP_LSB    = 0;
  localparam int WD_IRQ_EN_BIT  = 0;
  localparam int WD_FLAG_BIT    = 0;
  localparam int IRQ_A_PULSE_BIT = 0;
  localparam int IRQ_B_PULSE_BIT = 1;
  // ***************************************************
  // reset values
  // ***************************************************
  localparam logic [7:0] WD_CONTROL_RESET = 8'h00;
  localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
  localparam logic [7:0] IRQ_CTRL_RESET   = 8'h00;
  // ***************************************************
  // step codes and timing
  // ***************************************************
  typedef enum logic [1:0] {
    STEP_4S   = 2'h0,
    STEP_1S   = 2'h1,
    STEP_QTR  = 2'h2,
    STEP_16TH = 2'h3
  } step_sel_t;
  localparam int OSC_HZ       = 32768;
  localparam int REF_CLK_HZ   = 20000000;
  // 16 Hz tick = osc / 2048, slower steps derived by dividing it
  localparam int TICK16_DIV   = 2048;
  localparam int OSC_SYNC_LEN = 2;
  localparam int PULSE_CYCLES = 1;
endpackage : wd_pkg

// ### core/step_divider.sv
// file: divider from synchronised oscillator edges to the one watchdog step enable chosen by step_sel
`timescale 1ns/100ps
`default_nettype none
module step_divider #(
  parameter int DIV16 = 2048
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       osc_edge,
  input  wire logic [1:0] step_sel,
  output logic            step_en
);
  logic [11:0] pre_ff;
  logic [5:0]  post_ff;
  logic        tick16;
  logic        nxt_step;

  assign tick16 = osc_edge && (pre_ff == 12'(DIV16 - 1));

  // ***************************************************
  // prescaler and step counter
  // ***************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pre_ff <= 12'h000;
    end else if (osc_edge) begin
      pre_ff <= tick16 ? 12'h000 : pre_ff + 12'h001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      post_ff <= 6'h00;
    end else if (tick16) begin
      post_ff <= post_ff + 6'h01;
    end
  end

  always_comb begin
    case (step_sel)
      2'h0:    nxt_step = tick16 && (post_ff == 6'h3f);  // 4 s
      2'h1:    nxt_step = tick16 && (post_ff[3:0] == 4'hf);  // 1 s
      2'h2:    nxt_step = tick16 && (post_ff[1:0] == 2'h3);  // 1/4 s
      default: nxt_step = tick16;  // 1/16 s
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      step_en <= 1'b0;
    end else begin
      step_en <= nxt_step;
    end
  end
endmodule : step_divider
`default_nettype wire

// ### core/rtc_countdown_watchdog.sv
// file: countdown watchdog with expiry flag and two interrupt outputs
// Function
// R1: writing load field loads counter; zero halts, nonzero starts countdown
// R2: software loads only values one to thirty-one to start
// R3: step select 00=4 s, 01=1 s, 10=1/4 s, 11=1/16 s
// R4: period equals load count times step interval
// R5: counter decrements one per step from loaded bits six to two
// R6: a load during a running period takes effect immediately
// R7: first period may be one count off; later periods exact
// R8: reads return the live counter, not the written value
// R9: software reads twice and accepts matching values
// R10: repeat mode sets flag, reloads and restarts each period end
// R11: expiry flag sticks until software clears it
// R12: single-shot sets flag and stops counter at zero
// R13: software reloads nonzero value after single-shot expiry
// R14: each interrupt output gated by its own enable bit
// R15: enabled output pulses per expiry or follows flag level
// R16: pulse mode pulses each expiry even with flag still set
// R17: step timing derives from the 32.768 kHz oscillator
// R18: reset gives load zero, single-shot, four-second step, halted
// R19: expiry in the same cycle as flag clear keeps flag set
`timescale 1ns/100ps
`default_nettype none
module rtc_countdown_watchdog #(
  parameter int DIV16 = wd_pkg::TICK16_DIV
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       osc_clk_in,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  output logic            irq_out_a,
  output logic            irq_out_b
);
  logic [2:0] osc_sync_ff;
  logic       osc_edge;
  logic       step_en;
  logic       wd_repeat_select_ff;
  logic [4:0] wd_load_count_ff;
  logic [1:0] wd_step_select_ff;
  logic [4:0] count_ff;
  logic       wd_expired_flag_ff;
  logic       wd_irq_enable_a_ff;
  logic       wd_irq_enable_b_ff;
  logic       irq_a_pulse_mode_ff;
  logic       irq_b_pulse_mode_ff;
  logic       expire;
  logic       wr_ctl;
  logic       flag_clear;
  logic [7:0] nxt_rdata;

  // ***************************************************
  // oscillator synchroniser
  // ***************************************************
  // two flops before use, third only for edge detection
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      osc_sync_ff <= 3'h0;
    end else begin
      osc_sync_ff <= {osc_sync_ff[1:0], osc_clk_in};
    end
  end
  assign osc_edge = osc_sync_ff[1] && !osc_sync_ff[2];

  step_divider #(
    .DIV16   (DIV16)
  ) step_divider_inst (
    .ref_clk (ref_clk),
    .rst     (rst),
    .osc_edge(osc_edge),  // [R17]
    .step_sel(wd_step_select_ff),  // [R3]
    .step_en (step_en)
  );

  // ***************************************************
  // register writes
  // ***************************************************
  assign wr_ctl     = reg_wr && (reg_addr == wd_pkg::WD_CONTROL_COUNT_ADDR);
  // write one to the flag bit clears it
  assign flag_clear = reg_wr && (reg_addr == wd_pkg::FLAGS_ADDR) && reg_wdata[wd_pkg::WD_FLAG_BIT];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wd_repeat_select_ff <= wd_pkg::WD_CONTROL_RESET[wd_pkg::WD_REPEAT_BIT];  // [R18]
      wd_load_count_ff    <= wd_pkg::WD_CONTROL_RESET[wd_pkg::WD_LOAD_MSB:wd_pkg::WD_LOAD_LSB];
      wd_step_select_ff   <= wd_pkg::WD_CONTROL_RESET[wd_pkg::WD_STEP_MSB:wd_pkg::WD_STEP_LSB];
    end else if (wr_ctl) begin
      wd_repeat_select_ff <= reg_wdata[wd_pkg::WD_REPEAT_BIT];
      wd_load_count_ff    <= reg_wdata[wd_pkg::WD_LOAD_MSB:wd_pkg::WD_LOAD_LSB];
      wd_step_select_ff   <= reg_wdata[wd_pkg::WD_STEP_MSB:wd_pkg::WD_STEP_LSB];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wd_irq_enable_a_ff  <= wd_pkg::IRQ_ENABLE_RESET[wd_pkg::WD_IRQ_EN_BIT];
      wd_irq_enable_b_ff  <= wd_pkg::IRQ_ENABLE_RESET[wd_pkg::WD_IRQ_EN_BIT];
      irq_a_pulse_mode_ff <= wd_pkg::IRQ_CTRL_RESET[wd_pkg::IRQ_A_PULSE_BIT];
      irq_b_pulse_mode_ff <= wd_pkg::IRQ_CTRL_RESET[wd_pkg::IRQ_B_PULSE_BIT];
    end else if (reg_wr) begin
      if (reg_addr == wd_pkg::IRQ_A_ENABLE_ADDR) begin
        wd_irq_enable_a_ff <= reg_wdata[wd_pkg::WD_IRQ_EN_BIT];  // [R14]
      end
      if (reg_addr == wd_pkg::IRQ_B_ENABLE_ADDR) begin
        wd_irq_enable_b_ff <= reg_wdata[wd_pkg::WD_IRQ_EN_BIT];  // [R14]
      end
      if (reg_addr == wd_pkg::IRQ_CTRL_ADDR) begin
        irq_a_pulse_mode_ff <= reg_wdata[wd_pkg::IRQ_A_PULSE_BIT];
        irq_b_pulse_mode_ff <= reg_wdata[wd_pkg::IRQ_B_PULSE_BIT];
      end
    end
  end

  // ***************************************************
  // countdown
  // ***************************************************
  // step phase is not restarted on load, hence first period is up to one step short
  assign expire = step_en && (count_ff == 5'h01) && !wr_ctl;  // [R7]

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count_ff <= 5'h00;  // [R18]
    end else if (wr_ctl) begin
      count_ff <= reg_wdata[wd_pkg::WD_LOAD_MSB:wd_pkg::WD_LOAD_LSB];  // [R1] [R6]
    end else if (expire) begin
      count_ff <= wd_repeat_select_ff ? wd_load_count_ff : 5'h00;  // [R10] [R12] [R4]
    end else if (step_en && (count_ff != 5'h00)) begin
      count_ff <= count_ff - 5'h01;  // [R5]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wd_expired_flag_ff <= 1'b0;
    end else if (expire) begin
      wd_expired_flag_ff <= 1'b1;  // [R11] [R19]
    end else if (flag_clear) begin
      wd_expired_flag_ff <= 1'b0;  // [R11]
    end
  end

  // ***************************************************
  // interrupt outputs, active high
  // ***************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_out_a <= 1'b0;
      irq_out_b <= 1'b0;
    end else begin
      irq_out_a <= wd_irq_enable_a_ff && (irq_a_pulse_mode_ff ? expire : (wd_expired_flag_ff || expire));  // [R15] [R16]
      irq_out_b <= wd_irq_enable_b_ff && (irq_b_pulse_mode_ff ? expire : (wd_expired_flag_ff || expire));  // [R15] [R16]
    end
  end

  // ***************************************************
  // readback
  // ***************************************************
  always_comb begin
    nxt_rdata = 8'h00;
    case (reg_addr)
      wd_pkg::WD_CONTROL_COUNT_ADDR: nxt_rdata = {wd_repeat_select_ff, count_ff, wd_step_select_ff};  // [R8]
      wd_pkg::IRQ_A_ENABLE_ADDR:     nxt_rdata = {7'h00, wd_irq_enable_a_ff};
      wd_pkg::IRQ_B_ENABLE_ADDR:     nxt_rdata = {7'h00, wd_irq_enable_b_ff};
      wd_pkg::FLAGS_ADDR:            nxt_rdata = {7'h00, wd_expired_flag_ff};
      wd_pkg::IRQ_CTRL_ADDR:         nxt_rdata = {6'h00, irq_b_pulse_mode_ff, irq_a_pulse_mode_ff};
      default:                       nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= nxt_rdata;
    end
  end
endmodule : rtc_countdown_watchdog
`default_nettype wire

// ### testbench/rtc_countdown_watchdog_chk.sv
// checker: port-level assertions for the countdown watchdog
`timescale 1ns/100ps
`default_nettype none
module wd_port_chk #(
  parameter int DIV16 = 2048
) (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       irq_out_a,
  input wire logic       irq_out_b
);
  // ****************************************
  // shadow of enables and pulse modes
  // ****************************************
  logic en_a_ff;
  logic en_b_ff;
  logic pa_ff;
  logic pb_ff;
  logic irq_wr;
  assign irq_wr = reg_wr && (reg_addr == 8'h29 || reg_addr == 8'h2b || reg_addr == 8'h2e);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      {en_a_ff, en_b_ff, pa_ff, pb_ff} <= 4'h0;
    end else if (reg_wr) begin
      if (reg_addr == 8'h29) en_a_ff <= reg_wdata[0];
      if (reg_addr == 8'h2a) en_b_ff <= reg_wdata[0];
      if (reg_addr == 8'h2e) {pb_ff, pa_ff} <= reg_wdata[1:0];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ****************************************
  // assertions
  // ****************************************
  a_reset_quiet: assert property (disable iff (1'b0) rst |=> reg_rdata == 8'h00 && !irq_out_a && !irq_out_b)
    else $error("outputs not quiet after reset");
  // two idle cycles allowed since read data may land one edge late
  a_rdata_hold: assert property (!$past(reg_rd) && !$past(reg_rd, 2) |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_halt_read: assert property (reg_wr && reg_addr == 8'h2d && reg_wdata[6:2] == 5'h00 ##2
    reg_rd && reg_addr == 8'h2d ##1 !reg_rd |=> reg_rdata[6:2] == 5'h00)
    else $error("zero load not seen in count");
  a_gate_a: assert property (!en_a_ff && !$past(en_a_ff) |-> !irq_out_a)
    else $error("output a active while disabled");
  a_gate_b: assert property (!en_b_ff && !$past(en_b_ff) |-> !irq_out_b)
    else $error("output b active while disabled");
  a_pulse_width: assert property ($rose(irq_out_a) && pa_ff && $past(pa_ff) |=> !irq_out_a)
    else $error("pulse longer than one cycle");
  // a clear or enable write lands one edge before the output reacts, so skip that edge too
  a_level_hold: assert property (irq_out_a && !pa_ff && !irq_wr && !$past(irq_wr) |=> irq_out_a)
    else $error("level output dropped without clear");
  a_ab_match: assert property (en_a_ff && en_b_ff && pa_ff == pb_ff &&
    $past(en_a_ff && en_b_ff && pa_ff == pb_ff) |-> irq_out_a == irq_out_b)
    else $error("outputs differ under equal settings");
  c_pulse: cover property ($rose(irq_out_a) && pa_ff);
  c_level: cover property ($rose(irq_out_a) && !pa_ff);
  c_both: cover property (irq_out_a && irq_out_b);
endmodule : wd_port_chk
bind rtc_countdown_watchdog wd_port_chk #(.DIV16(DIV16)) wd_port_chk_inst (.ref_clk(ref_clk), .rst(rst),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .irq_out_a(irq_out_a), .irq_out_b(irq_out_b));
`default_nettype wire

// ### testbench/rtc_countdown_watchdog_bench.sv
// bench: register-level tests of the countdown watchdog
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; $display("unexpected %0t mismatch", $time); end end
module rtc_countdown_watchdog_bench;
  logic       ref_clk    = 1'b0;
  logic       rst        = 1'b1;
  logic       osc_clk_in = 1'b0;
  logic       reg_wr     = 1'b0;
  logic       reg_rd     = 1'b0;
  logic [7:0] reg_addr   = 8'h00;
  logic [7:0] reg_wdata  = 8'h00;
  logic [7:0] reg_rdata;
  logic       irq_out_a;
  logic       irq_out_b;
  logic [7:0] d;
  logic [7:0] d2;
  logic [7:0] ra [5]     = '{8'h2d, 8'h29, 8'h2a, 8'h2e, 8'h00};
  int         err_total  = 0;
  int         compares   = 0;
  int         cyc        = 0;
  int         t0;
  // short divider keeps the 4 s step near a thousand cycles
  rtc_countdown_watchdog #(.DIV16(2)) rtc_countdown_watchdog_inst (.ref_clk(ref_clk), .rst(rst),
    .osc_clk_in(osc_clk_in), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq_out_a(irq_out_a), .irq_out_b(irq_out_b));
  initial forever #25 ref_clk = ~ref_clk;
  initial forever begin
    repeat (4) @(posedge ref_clk);
    #1 osc_clk_in = ~osc_clk_in;
  end
  always @(posedge ref_clk) cyc <= cyc + 1;
  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    tick;
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, v};
    tick;
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    tick;
    {reg_rd, reg_addr} = {1'b1, a};
    tick;
    reg_rd = 1'b0;
    tick;
    v = reg_rdata;
  endtask : rd
  task automatic chg;
    d = reg_rdata;
    while (reg_rdata === d) tick;
  endtask : chg
  task automatic wait_a;
    int n;
    n = 0;
    while (irq_out_a !== 1'b1 && n < 2000) begin
      tick;
      n++;
    end
    if (n >= 2000) begin
      err_total++;
      $display("unexpected %0t interrupt a never rose", $time);
    end
  endtask : wait_a
  task automatic stop_test;
    $display("counts: %0d compares, %0d mismatches", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    stop_test;
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    #1 rst = 1'b0;
    foreach (ra[i]) begin
      rd(ra[i], d);
      `CHK(d, 8'h00)
    end
    $display("test reset done");
    for (int s = 0; s < 4; s++) begin
      wr(8'h2d, {1'b0, 5'd31, s[1:0]});
      tick;
      {reg_rd, reg_addr} = {1'b1, 8'h2d};
      // polling every cycle; the first period may be short
      repeat (2) tick;
      chg;
      t0 = cyc;
      chg;
      `CHK(cyc - t0, 1024 >> (2 * s))
      `CHK(reg_rdata, d - 8'h04)
      reg_rd = 1'b0;
    end
    $display("test steps done");
    wr(8'h2d, 8'h7c);
    wr(8'h2d, 8'h50);
    rd(8'h2d, d);
    rd(8'h2d, d2);
    `CHK(d2, d)
    `CHK(d, 8'h50)
    wr(8'h2d, 8'h03);
    rd(8'h2d, d);
    `CHK(d, 8'h03)
    $display("test reload done");
    wr(8'h29, 8'h01);
    wr(8'h2d, 8'h0b);
    wait_a;
    `CHK(irq_out_b, 1'b0)
    rd(8'h2d, d);
    `CHK(d, 8'h03)
    repeat (40) tick;
    `CHK(irq_out_a, 1'b1)
    rd(8'h2b, d);
    `CHK(d[0], 1'b1)
    wr(8'h2b, 8'h01);
    tick;
    `CHK(irq_out_a, 1'b0)
    $display("test single shot done");
    wr(8'h2a, 8'h01);
    wr(8'h2e, 8'h03);
    wr(8'h2d, 8'h8f);
    wait_a;
    `CHK(irq_out_b, 1'b1)
    t0 = cyc;
    tick;
    `CHK(irq_out_a, 1'b0)
    wait_a;
    `CHK(cyc - t0, 48)
    `CHK(irq_out_a, 1'b1)
    rd(8'h2d, d);
    `CHK(d, 8'h8f)
    $display("test repeat done");
    stop_test;
  end
endmodule : rtc_countdown_watchdog_bench
`default_nettype wire
